/* File: dv/irq_far_end.sv */
`timescale 1ns/1ns
// Far side: peripherals raising requests, external pins, and the core taking normal vectors.
module irq_far_end (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [19:0] want_req,
  input wire logic [3:0] want_pin,
  input wire logic take,
  input wire logic irq,
  output logic [19:0] source_request,
  output logic [3:0] ext_pin,
  output logic normal_vector_read
);
  // The core reads a vector only while an interrupt is raised, and for one cycle only.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      source_request <= 20'h0;
      ext_pin <= 4'h0;
      normal_vector_read <= 1'b0;
    end else begin
      source_request <= want_req;
      ext_pin <= want_pin;
      normal_vector_read <= take && irq && !normal_vector_read;
    end
  end
endmodule

/* File: dv/nest_irq_ctrl_sva.sv */
`timescale 1ns/1ns
// Watches the register port and the request outputs of the controller.
module nest_irq_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [15:0] vector_base,
  input wire logic fiq,
  input wire logic irq,
  input wire logic [2:0] normal_priority
);
  logic [1:0] nest;
  // Read access decode shared by the field checks.
  wire rd_acc = psel && penable && !pwrite;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Shadow of the nesting bits, since the priority output depends on them.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nest <= 2'h0;
    end else if (psel && penable && pwrite && paddr == nest_irq_pkg::addr_nesting_control) begin
      nest <= pwdata[1:0];
    end
  end
  sequence s_fv_setup;
    psel && !penable && !pwrite && paddr == nest_irq_pkg::addr_fast_vector;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  property p_vec_base;
    s_fv_setup ##1 s_access |-> prdata[22:7] == $past(vector_base);
  endproperty
  a_vec_base: assert property (p_vec_base) else $error("vector base field wrong");
  property p_vec_frame;
    s_fv_setup ##1 s_access |-> prdata[31:23] == 9'h0 && prdata[1:0] == 2'h0 &&
      prdata[6:2] <= 5'd19;
  endproperty
  a_vec_frame: assert property (p_vec_frame) else $error("vector frame wrong");
  property p_fiq_first;
    irq |-> !fiq;
  endproperty
  a_fiq_first: assert property (p_fiq_first) else $error("irq beside fiq");
  property p_prio_rsv;
    rd_acc && paddr == nest_irq_pkg::addr_source_priority_c |-> prdata[31:15] == 17'h0 &&
      prdata[11] == 1'b0 && prdata[7] == 1'b0 && prdata[3] == 1'b0;
  endproperty
  a_prio_rsv: assert property (p_prio_rsv) else $error("priority spare bits set");
  property p_isr_rsv;
    rd_acc && (paddr == nest_irq_pkg::addr_normal_in_service ||
      paddr == nest_irq_pkg::addr_fast_in_service) |-> prdata[31:8] == 24'h0;
  endproperty
  a_isr_rsv: assert property (p_isr_rsv) else $error("in-service wide");
  property p_flat_prio;
    irq && !nest[0] |-> normal_priority == 3'h0;
  endproperty
  a_flat_prio: assert property (p_flat_prio) else $error("priority used");
  property p_trig_rsv;
    rd_acc && paddr == nest_irq_pkg::addr_external_trigger_select |-> prdata[31:8] == 24'h0;
  endproperty
  a_trig_rsv: assert property (p_trig_rsv) else $error("trigger spare bits set");
  property p_clr_rd;
    rd_acc && paddr == nest_irq_pkg::addr_external_edge_clear |-> prdata == 32'h0;
  endproperty
  a_clr_rd: assert property (p_clr_rd) else $error("edge clear reads back");
endmodule
bind nest_irq_ctrl nest_irq_chk u_chk (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .vector_base, .fiq, .irq, .normal_priority);

/* File: dv/test_nest_irq_ctrl.sv */
`timescale 1ns/1ns
// Drives the register port and the far side, and compares what comes back.
module test_nest_irq_ctrl;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [19:0] want_req = 20'h0;
  logic [3:0] want_pin = 4'h0;
  logic take = 1'b0;
  logic [19:0] fast_en = 20'h0;
  logic [19:0] norm_en = 20'h0;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic pready, pslverr, perr, fiq, irq, normal_vector_read, event_irq;
  logic [19:0] source_request;
  logic [3:0] ext_pin;
  logic [4:0] normal_source;
  logic [2:0] normal_priority;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int clr_of [4] = '{13, 14, 18, 19};
  logic [31:0] src_of [4] = '{nest_irq_pkg::src_ext0, nest_irq_pkg::src_ext1,
    nest_irq_pkg::src_ext2, nest_irq_pkg::src_ext3};
  localparam logic [15:0] vb = 16'h5a3c;
  always #2 clk_sys = ~clk_sys;
  nest_irq_ctrl u_dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .source_request, .ext_pin, .fast_enable_reg(fast_en),
    .normal_enable_reg(norm_en), .other_priority(60'h0), .vector_base(vb),
    .normal_vector_read, .fiq, .irq, .normal_source, .normal_priority, .event_irq);
  irq_far_end u_far (.clk_sys, .rst, .want_req, .want_pin, .take, .irq, .source_request,
    .ext_pin, .normal_vector_read);
  function automatic logic [31:0] vec(input logic [4:0] s);
    return {9'h0, vb, s, 2'h0};
  endfunction
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error are taken at the edge that sees pready.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // A hang is cut short well beyond the few hundred cycles the sequence needs.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    wt(6);
    rst <= 1'b0;
    rd(nest_irq_pkg::addr_source_priority_c, 32'h0);
    rd(nest_irq_pkg::addr_nesting_control, 32'h0);
    rd(nest_irq_pkg::addr_external_trigger_select, 32'h0);
    rd(nest_irq_pkg::addr_normal_in_service, 32'h0);
    rd(nest_irq_pkg::addr_fast_in_service, 32'h0);
    xfer(1'b0, 32'hffff0000, 32'h0);
    chk({31'h0, perr}, 32'h1);
    xfer(1'b1, nest_irq_pkg::addr_source_priority_c, 32'hffffffff);
    rd(nest_irq_pkg::addr_source_priority_c, 32'h7777);
    xfer(1'b1, nest_irq_pkg::addr_source_priority_c, 32'h5503);
    rd(nest_irq_pkg::addr_source_priority_c, 32'h5503);
    // A vector read with nesting off is flagged as an event.
    rd(nest_irq_pkg::addr_fast_vector, vec(5'd0));
    chk({31'h0, event_irq}, 32'h0);
    xfer(1'b1, nest_irq_pkg::addr_event_mask, 32'h1);
    wt(1);
    chk({31'h0, event_irq}, 32'h1);
    xfer(1'b1, nest_irq_pkg::addr_event_status, 32'h1);
    wt(1);
    chk({31'h0, event_irq}, 32'h0);
    // Nesting off: fast wins over normal whatever the levels.
    fast_en <= 20'h04000;
    norm_en <= 20'h00400;
    want_req <= 20'h04400;
    wt(3);
    chk({fiq, irq}, 2'b10);
    want_req <= 20'h04000;
    xfer(1'b1, nest_irq_pkg::addr_nesting_control, 32'h3);
    wt(2);
    rd(nest_irq_pkg::addr_fast_vector, vec(5'd14));
    wt(1);
    chk({31'h0, fiq}, 32'h0);
    rd(nest_irq_pkg::addr_fast_in_service, 32'h8);
    fast_en <= 20'h04400;
    want_req <= 20'h04400;
    wt(3);
    chk({31'h0, fiq}, 32'h1);
    rd(nest_irq_pkg::addr_fast_vector, vec(5'd10));
    wt(1);
    chk({31'h0, fiq}, 32'h0);
    rd(nest_irq_pkg::addr_fast_in_service, 32'h9);
    xfer(1'b1, nest_irq_pkg::addr_fast_in_service, 32'hff);
    wt(1);
    chk({31'h0, fiq}, 32'h1);
    rd(nest_irq_pkg::addr_fast_in_service, 32'h8);
    xfer(1'b1, nest_irq_pkg::addr_fast_in_service, 32'hff);
    rd(nest_irq_pkg::addr_fast_in_service, 32'h0);
    // Normal nesting through the core's vector read.
    fast_en <= 20'h0;
    norm_en <= 20'h04000;
    want_req <= 20'h04000;
    wt(3);
    chk({irq, normal_priority}, 4'hb);
    chk({27'h0, normal_source}, nest_irq_pkg::src_i2c_slave);
    take <= 1'b1;
    wt(1);
    take <= 1'b0;
    wt(4);
    chk({31'h0, irq}, 32'h0);
    rd(nest_irq_pkg::addr_normal_in_service, 32'h8);
    xfer(1'b1, nest_irq_pkg::addr_normal_in_service, 32'hff);
    wt(1);
    chk({31'h0, irq}, 32'h1);
    // External pins: pin i uses trigger mode i; idle levels chosen to be inactive.
    want_req <= 20'h0;
    want_pin <= 4'ha;
    xfer(1'b1, nest_irq_pkg::addr_nesting_control, 32'h0);
    norm_en <= 20'h31800;
    xfer(1'b1, nest_irq_pkg::addr_external_trigger_select, 32'he4);
    for (int i = 0; i < 4; i++) begin
      wt(6);
      chk({31'h0, irq}, 32'h0);
      want_pin[i] <= ~want_pin[i];
      wt(6);
      chk({31'h0, irq}, 32'h1);
      chk({24'h0, normal_priority, normal_source}, src_of[i]);
      want_pin[i] <= ~want_pin[i];
      wt(6);
      chk({31'h0, irq}, {31'h0, i >= 2});
      xfer(1'b1, nest_irq_pkg::addr_external_edge_clear, 32'h1 << clr_of[i]);
      wt(2);
      chk({31'h0, irq}, 32'h0);
    end
    conclude();
  end
endmodule

/* File: verilog/ext_trigger.sv */
`timescale 1ns/1ns
// One external interrupt pin: synchroniser, trigger decode and edge latch.
module ext_trigger (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pin,
  input wire logic [1:0] mode,
  input wire logic clear,
  output logic request
);
  logic sync_a;
  logic sync_b;
  logic prev;
  logic latched;
  wire rise = sync_b & ~prev;
  wire fall = ~sync_b & prev;
  wire is_edge = mode[1];
  wire edge_hit = (mode == nest_irq_pkg::trig_rising) ? rise : fall;

  // Two flops before any logic sees the pin; only sync_b is looked at.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      prev <= sync_b;
    end
  end

  // A fresh edge in the clear cycle wins, so no edge is lost.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      latched <= 1'b0;
    end else if (is_edge && edge_hit) begin
      latched <= 1'b1;
    end else if (clear || !is_edge) begin
      latched <= 1'b0;
    end
  end

  // Level modes follow the pin; edge modes hold until cleared.
  assign request = is_edge ? latched :
    ((mode == nest_irq_pkg::trig_low_level) ? ~sync_b : sync_b);
endmodule

/* File: verilog/nest_irq_ctrl.sv */
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
// How it works
// - The third priority register holds 3-bit levels for ext 3, ext 2, SPI slave, I2C slave.
// - Nesting control bit 1 enables fast nesting and priority, bit 0 does so for normal.
// - With nesting off, both paths still deliver, in source order, fast outranking normal.
// - Reading the normal vector with nesting on sets the normal in-service bit of its level.
// - Reading the fast vector with nesting on sets the fast in-service bit of its level.
// - Each write to an in-service register clears only its lowest set bit.
// - The fast vector reads zero, vector base at 22:7, source at 6:2, zero at 1:0.
// - Four external pins, each level, rising-edge or falling-edge triggered.
// - An edge request stays latched until software writes its edge clear bit.
// - Trigger field 11 is falling, 10 rising, 01 low level, 00 high level.
// - Edge clear bits are 19, 18, 14 and 13 for external pins 3, 2, 1 and 0.
// - Level zero is the highest priority and level seven the lowest.
module nest_irq_ctrl (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [19:0] source_request,
  input wire logic [3:0] ext_pin,
  input wire logic [19:0] fast_enable_reg,
  input wire logic [19:0] normal_enable_reg,
  input wire logic [59:0] other_priority,
  input wire logic [15:0] vector_base,
  input wire logic normal_vector_read,
  output logic fiq,
  output logic irq,
  output logic [4:0] normal_source,
  output logic [2:0] normal_priority,
  output logic event_irq
);
  logic [31:0] source_priority_c;
  logic [1:0] nesting_control;
  logic [7:0] external_trigger_select;
  logic [7:0] normal_in_service;
  logic [7:0] fast_in_service;
  logic [1:0] event_status;
  logic [1:0] event_mask;
  logic [3:0] ext_request;
  logic [19:0] pending;
  logic [2:0] src_prio [0:19];
  logic [4:0] fast_src;
  logic [2:0] fast_prio;
  logic fast_found;
  logic [4:0] norm_src;
  logic [2:0] norm_prio;
  logic norm_found;

  // Access decode: every transfer finishes in its first access cycle.
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire hit_prio = paddr == nest_irq_pkg::addr_source_priority_c;
  wire hit_nest = paddr == nest_irq_pkg::addr_nesting_control;
  wire hit_trig = paddr == nest_irq_pkg::addr_external_trigger_select;
  wire hit_clre = paddr == nest_irq_pkg::addr_external_edge_clear;
  wire hit_nis = paddr == nest_irq_pkg::addr_normal_in_service;
  wire hit_fvec = paddr == nest_irq_pkg::addr_fast_vector;
  wire hit_fis = paddr == nest_irq_pkg::addr_fast_in_service;
  wire hit_evs = paddr == nest_irq_pkg::addr_event_status;
  wire hit_evm = paddr == nest_irq_pkg::addr_event_mask;
  wire mapped = hit_prio | hit_nest | hit_trig | hit_clre | hit_nis | hit_fvec |
    hit_fis | hit_evs | hit_evm;
  // Nesting enables of the two paths, taken straight from the control register.
  wire fast_nest = nesting_control[nest_irq_pkg::pos_fast_nest_enable];
  wire normal_nest = nesting_control[nest_irq_pkg::pos_normal_nest_enable];
  wire fvec_read = rd & hit_fvec;
  wire fis_write = wr & hit_fis;
  wire nis_write = wr & hit_nis;

  // Write strobes of the plain registers, one per address.
  wire prio_write = wr & hit_prio;
  wire nest_write = wr & hit_nest;
  wire trig_write = wr & hit_trig;
  wire mask_write = wr & hit_evm;
  wire status_write = wr & hit_evs;

  // Edge clear bits are picked out of the written word; a zero leaves its latch alone.
  wire [3:0] edge_clear_bits = {pwdata[nest_irq_pkg::pos_ext3_clear],
    pwdata[nest_irq_pkg::pos_ext2_clear], pwdata[nest_irq_pkg::pos_ext1_clear],
    pwdata[nest_irq_pkg::pos_ext0_clear]};
  wire [3:0] edge_clear = (wr & hit_clre) ? edge_clear_bits : 4'h0;

  // No wait states: the decode settles in the setup cycle, so an access never
  // has to be stretched. Unmapped addresses answer with an error instead.
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // One trigger unit per external pin.
  // Each unit synchronises its own pin, so the pins may change at any time.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_ext
      ext_trigger u_trig (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin(ext_pin[g]),
        .mode(external_trigger_select[2 * g +: 2]),
        .clear(edge_clear[g]),
        .request(ext_request[g])
      );
    end
  endgenerate

  // External pins take their fixed slots; the rest come from peripherals.
  always_comb begin
    pending = source_request;
    pending[nest_irq_pkg::src_ext0] = ext_request[0];
    pending[nest_irq_pkg::src_ext1] = ext_request[1];
    pending[nest_irq_pkg::src_ext2] = ext_request[2];
    pending[nest_irq_pkg::src_ext3] = ext_request[3];
  end

  // Priority per source; four fields come from the local priority register.
  always_comb begin
    for (int i = 0; i < 20; i++) begin
      src_prio[i] = other_priority[3 * i +: 3];
    end
    src_prio[nest_irq_pkg::src_ext3] =
      source_priority_c[nest_irq_pkg::pos_ext3_priority +: 3];
    src_prio[nest_irq_pkg::src_ext2] =
      source_priority_c[nest_irq_pkg::pos_ext2_priority +: 3];
    src_prio[nest_irq_pkg::src_spi_slave] =
      source_priority_c[nest_irq_pkg::pos_spi_slave_priority +: 3];
    src_prio[nest_irq_pkg::src_i2c_slave] =
      source_priority_c[nest_irq_pkg::pos_i2c_slave_priority +: 3];
  end

  // Arbitration for one path. With nesting on the lowest level wins and a
  // level at or below the highest in-service level is held back; with
  // nesting off the lowest source number wins and levels are ignored.
  // A function, not a task, so the calling processes also wake on src_prio.
  function automatic void arbitrate(input logic [19:0] req, input logic nest,
    input logic [7:0] ins, output logic found, output logic [4:0] src,
    output logic [2:0] prio);
    logic blocked;
    found = 1'b0;
    src = 5'h00;
    prio = 3'h0;
    for (int i = 0; i < 20; i++) begin
      blocked = 1'b0;
      for (int k = 0; k < 8; k++) begin
        if (nest && ins[k] && (k <= int'(src_prio[i]))) begin
          blocked = 1'b1;
        end
      end
      if (req[i] && !blocked) begin
        if (!found || (nest && (src_prio[i] < prio))) begin
          found = 1'b1;
          src = 5'(i);
          prio = nest ? src_prio[i] : 3'h0;
        end
      end
    end
  endfunction

  // Candidates of each path: pending sources that software has enabled.
  wire [19:0] fast_cand = pending & fast_enable_reg;
  wire [19:0] norm_cand = pending & normal_enable_reg;

  // Fast path winner.
  always_comb begin
    arbitrate(fast_cand, fast_nest, fast_in_service, fast_found, fast_src, fast_prio);
  end

  // Normal path winner; it only reaches the core when no fast request stands.
  always_comb begin
    arbitrate(norm_cand, normal_nest, normal_in_service, norm_found, norm_src, norm_prio);
  end

  // A fast request always takes the core first, whatever the nesting bits say.
  assign fiq = fast_found;
  assign irq = norm_found & ~fast_found;
  assign normal_source = norm_src;
  assign normal_priority = norm_prio;
  // The event output is a level, high while an unmasked status bit is set.
  assign event_irq = |(event_status & event_mask);

  // Plain read/write configuration registers, one short process each so that
  // a wrong strobe can only ever corrupt its own register.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      source_priority_c <= nest_irq_pkg::reset_zero;
    end else if (prio_write) begin
      source_priority_c <= pwdata & nest_irq_pkg::source_priority_c_mask;
    end
  end

  // Nesting enables; the spare bits of the word are dropped.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nesting_control <= 2'h0;
    end else if (nest_write) begin
      nesting_control <= pwdata[1:0];
    end
  end

  // Trigger modes, two bits per external pin.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      external_trigger_select <= 8'h00;
    end else if (trig_write) begin
      external_trigger_select <= pwdata[7:0];
    end
  end

  // Event mask; it gates only the event output, never the status bits.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      event_mask <= 2'h0;
    end else if (mask_write) begin
      event_mask <= pwdata[1:0];
    end
  end

  // In-service stacks: a vector read pushes a level, a write pops the top.
  // A push needs nesting on and a winner; without one a fast vector read is only flagged and a normal one is ignored.
  wire [7:0] nis_set = (normal_vector_read && normal_nest && norm_found) ?
    (8'h01 << norm_prio) : 8'h00;
  wire [7:0] fis_set = (fvec_read && fast_nest && fast_found) ?
    (8'h01 << fast_prio) : 8'h00;
  wire [7:0] nis_popped = nis_write ? (normal_in_service & (normal_in_service - 8'h01))
    : normal_in_service;
  wire [7:0] fis_popped = fis_write ? (fast_in_service & (fast_in_service - 8'h01))
    : fast_in_service;

  // Normal in-service register. A pop and a push may meet in one cycle; the
  // push is kept so that a freshly taken level is never lost.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      normal_in_service <= 8'h00;
    end else begin
      normal_in_service <= nis_popped | nis_set;
    end
  end

  // Fast in-service register, the same scheme as the normal one.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fast_in_service <= 8'h00;
    end else begin
      fast_in_service <= fis_popped | fis_set;
    end
  end

  // Misuse events: a fast vector read with nothing to serve or nesting off,
  // and a pop of an empty in-service register. Set beats write-one-clear.
  wire bad_fast_read = fvec_read && !(fast_nest && fast_found);
  wire empty_pop = (nis_write && normal_in_service == 8'h00) ||
    (fis_write && fast_in_service == 8'h00);
  wire [1:0] ev_set = {empty_pop, bad_fast_read};
  wire [1:0] ev_clr = status_write ? pwdata[1:0] : 2'h0;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      event_status <= 2'h0;
    end else begin
      event_status <= (event_status & ~ev_clr) | ev_set;
    end
  end

  // Read words with their spare bits forced to zero.
  // The vector word is built live and captured in the setup cycle like the rest.
  wire [31:0] fast_vector = {9'h000, vector_base, fast_src, 2'h0};
  wire [31:0] nest_word = {30'h0, nesting_control};
  wire [31:0] trig_word = {24'h0, external_trigger_select};
  wire [31:0] nis_word = {24'h0, normal_in_service};
  wire [31:0] fis_word = {24'h0, fast_in_service};
  wire [31:0] status_word = {30'h0, event_status};
  wire [31:0] mask_word = {30'h0, event_mask};

  // Read data mux; unmapped addresses and the edge clear return zero.
  wire [31:0] next_prdata =
    hit_prio ? source_priority_c :
    hit_nest ? nest_word :
    hit_trig ? trig_word :
    hit_nis ? nis_word :
    hit_fvec ? fast_vector :
    hit_fis ? fis_word :
    hit_evs ? status_word :
    hit_evm ? mask_word : 32'h00000000;

  // Read data is registered during the setup cycle so it is stable in access.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end
endmodule

/* File: verilog/nest_irq_pkg.sv */
package nest_irq_pkg;
  localparam int unsigned num_sources = 20;
  localparam int unsigned num_ext = 4;
  // Register byte addresses.
  localparam logic [31:0] addr_source_priority_c = 32'hffff0028;
  localparam logic [31:0] addr_nesting_control = 32'hffff0030;
  localparam logic [31:0] addr_external_trigger_select = 32'hffff0034;
  localparam logic [31:0] addr_external_edge_clear = 32'hffff0038;
  localparam logic [31:0] addr_normal_in_service = 32'hffff003c;
  localparam logic [31:0] addr_fast_vector = 32'hffff011c;
  localparam logic [31:0] addr_fast_in_service = 32'hffff013c;
  localparam logic [31:0] addr_event_status = 32'hffff0140;
  localparam logic [31:0] addr_event_mask = 32'hffff0144;
  // Reset values.
  localparam logic [31:0] reset_zero = 32'h00000000;
  // Priority field positions (low bit of each 3-bit field).
  localparam int unsigned pos_ext3_priority = 12;
  localparam int unsigned pos_ext2_priority = 8;
  localparam int unsigned pos_spi_slave_priority = 4;
  localparam int unsigned pos_i2c_slave_priority = 0;
  localparam logic [31:0] source_priority_c_mask = 32'h00007777;
  // Nesting control bits.
  localparam int unsigned pos_normal_nest_enable = 0;
  localparam int unsigned pos_fast_nest_enable = 1;
  // Edge clear bit positions for external pins 0..3.
  localparam int unsigned pos_ext0_clear = 13;
  localparam int unsigned pos_ext1_clear = 14;
  localparam int unsigned pos_ext2_clear = 18;
  localparam int unsigned pos_ext3_clear = 19;
  // Source numbers of the prioritised sources.
  localparam int unsigned src_spi_slave = 10;
  localparam int unsigned src_ext0 = 11;
  localparam int unsigned src_ext1 = 12;
  localparam int unsigned src_i2c_slave = 14;
  localparam int unsigned src_ext2 = 16;
  localparam int unsigned src_ext3 = 17;
  // Trigger field encodings.
  localparam logic [1:0] trig_high_level = 2'h0;
  localparam logic [1:0] trig_low_level = 2'h1;
  localparam logic [1:0] trig_rising = 2'h2;
  localparam logic [1:0] trig_falling = 2'h3;
  // Event status bits.
  localparam int unsigned ev_bad_fast_read = 0;
  localparam int unsigned ev_empty_in_service_write = 1;
  localparam int unsigned num_events = 2;
endpackage
